// ---- verilog/rtcca_top.sv ----
// Purpose: control, calendar counting and alarm of the calendar clock
// Assumes: srcTick is a one-cycle pulse per low-frequency source edge
// Notes: clock_config is cleared by rst (power-on) only
`timescale 1ns/1ps
`include "rtcca_regs.svh"

module rtcca_top #(
  parameter int TICKS_HALF = `RTCCA_TICKS_HALF
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic sysRst,
  // register port
  input wire rtcca_pkg::rtcca_bus_t bus,
  output logic [7:0] rdData,
  // low-frequency source
  input wire logic srcTick,
  input wire logic srcClkLevel,
  // clock pin and event
  output logic pinOut,
  output logic pinOe,
  output logic alarmEvent
);
  import rtcca_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic enable, wren, oe;
  logic [1:0] tPtr, aPtr, padSel;
  logic [7:0] cal, rpt;
  logic aEn, chime;
  logic [3:0] alarm_interval_mask;
  rtcca_unlock_t unlock;
  rtcca_time_t tm, next_tm, alm;
  logic [15:0] presc;
  logic [9:0] adjLeft;
  logic adjNeg, checkDue, checkHalf;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wrCfg = bus.wr && bus.addr == `RTCCA_OFS_CFG;
  wire wrCal = bus.wr && bus.addr == `RTCCA_OFS_CAL;
  wire wrPad = bus.wr && bus.addr == `RTCCA_OFS_PAD;
  wire wrAcfg = bus.wr && bus.addr == `RTCCA_OFS_ACFG;
  wire wrRpt = bus.wr && bus.addr == `RTCCA_OFS_RPT;
  wire wrKey = bus.wr && bus.addr == `RTCCA_OFS_KEY;
  wire wrTvl = bus.wr && bus.addr == `RTCCA_OFS_TVL && wren;
  wire wrTvh = bus.wr && bus.addr == `RTCCA_OFS_TVH && wren;
  wire wrAvl = bus.wr && bus.addr == `RTCCA_OFS_AVL;
  wire wrAvh = bus.wr && bus.addr == `RTCCA_OFS_AVH;
  wire accTvh = (bus.wr || bus.rd) && bus.addr == `RTCCA_OFS_TVH;
  wire accAvh = (bus.wr || bus.rd) && bus.addr == `RTCCA_OFS_AVH;
  wire secWrite = wrTvl && tPtr == 2'b00;
  wire almDateOk = wren || aPtr == 2'b00;

  // ----------------------------------------------------------------
  // second prescaler with drift calibration
  // ----------------------------------------------------------------
  localparam logic [15:0] FULL = 16'(2 * TICKS_HALF);
  localparam logic [15:0] HALF = 16'(TICKS_HALF);
  localparam logic [15:0] SYNC_AT = 16'(2 * TICKS_HALF - `RTCCA_SYNC_TICKS);
  wire adjActive = adjLeft != 10'h000;
  wire [15:0] step = !adjActive ? 16'h0001 : (adjNeg ? 16'h0000 : 16'h0002);
  wire countOn = enable && srcTick;
  wire [15:0] presSum = presc + step;
  wire secTick = countOn && presSum >= FULL;
  wire halfTick = countOn && presc < HALF && presSum >= HALF;
  wire [15:0] next_presc = secTick ? presSum - FULL : presSum;
  wire half_second_status = presc >= HALF;
  wire syncFlag = enable && presc >= SYNC_AT;
  wire minTick = secTick && tm.second == 8'h59;
  wire [7:0] calMag = cal[7] ? 8'(~cal + 8'h01) : cal;
  wire [9:0] adjLoad = 10'(calMag) * 10'(`RTCCA_CAL_STEP);

  // ----------------------------------------------------------------
  // BCD calendar arithmetic
  // ----------------------------------------------------------------
  function automatic logic [8:0] bcdNext(input logic [7:0] v,
                                         input logic [7:0] last,
                                         input logic [7:0] first);
    logic [8:0] r;
    r = {1'b0, v + 8'h01};
    if (v == last) begin
      r = {1'b1, first};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return r;
  endfunction

  function automatic logic [7:0] lastDay(input logic [7:0] m,
                                         input logic [7:0] y);
    logic leap;
    logic [7:0] r;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    r = 8'h31;
    if (m == 8'h02) begin
      r = leap ? 8'h29 : 8'h28;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      r = 8'h30;
    end
    return r;
  endfunction

  logic [8:0] cSec, cMin, cHour, cDay, cWday, cMon, cYear;

  always_comb begin
    next_tm = tm;
    cSec = bcdNext(tm.second, 8'h59, 8'h00);
    cMin = bcdNext(tm.minute, 8'h59, 8'h00);
    cHour = bcdNext(tm.hour, 8'h23, 8'h00);
    cDay = bcdNext(tm.day, lastDay(tm.month, tm.year), 8'h01);
    cWday = bcdNext(tm.wday, 8'h06, 8'h00);
    cMon = bcdNext(tm.month, 8'h12, 8'h01);
    cYear = bcdNext(tm.year, 8'h99, 8'h00);
    if (secTick) begin
      next_tm.second = cSec[7:0];
      if (cSec[8]) begin
        next_tm.minute = cMin[7:0];
        if (cMin[8]) begin
          next_tm.hour = cHour[7:0];
          if (cHour[8]) begin
            next_tm.day = cDay[7:0];
            next_tm.wday = cWday[7:0];
            if (cDay[8]) begin
              next_tm.month = cMon[7:0];
              if (cMon[8]) begin
                next_tm.year = cYear[7:0];
              end
            end
          end
        end
      end
    end
    if (wrTvh) begin
      unique case (tPtr)
        2'b00: next_tm.minute = bus.wdata & `RTCCA_MASK_MIN;
        2'b01: next_tm.wday = bus.wdata & `RTCCA_MASK_WDAY;
        2'b10: next_tm.month = bus.wdata & `RTCCA_MASK_MONTH;
        2'b11: next_tm.minute = tm.minute;
      endcase
    end
    if (wrTvl) begin
      unique case (tPtr)
        2'b00: next_tm.second = bus.wdata & `RTCCA_MASK_SEC;
        2'b01: next_tm.hour = bus.wdata & `RTCCA_MASK_HOUR;
        2'b10: next_tm.day = bus.wdata & `RTCCA_MASK_DAY;
        2'b11: next_tm.year = bus.wdata & `RTCCA_MASK_YEAR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // alarm compare
  // ----------------------------------------------------------------
  wire mSec1 = tm.second[3:0] == alm.second[3:0];
  wire mSec = tm.second == alm.second;
  wire mMin1 = tm.minute[3:0] == alm.minute[3:0];
  wire mMin = tm.minute == alm.minute;
  wire mHour = tm.hour == alm.hour;
  wire mWday = tm.wday == alm.wday;
  wire mDay = tm.day == alm.day;
  wire mMon = tm.month == alm.month;
  logic almMatch;

  // Feb 29 exists only in leap years
  always_comb begin
    unique case (alarm_interval_mask)
      4'h0: almMatch = 1'b1;
      4'h1: almMatch = !checkHalf;
      4'h2: almMatch = !checkHalf && mSec1;
      4'h3: almMatch = !checkHalf && mSec;
      4'h4: almMatch = !checkHalf && mSec && mMin1;
      4'h5: almMatch = !checkHalf && mSec && mMin;
      4'h6: almMatch = !checkHalf && mSec && mMin && mHour;
      4'h7: almMatch = !checkHalf && mSec && mMin && mHour && mWday;
      4'h8: almMatch = !checkHalf && mSec && mMin && mHour && mDay;
      4'h9: almMatch = !checkHalf && mSec && mMin && mHour && mDay && mMon;
      default: almMatch = 1'b0;
    endcase
  end

  wire fire = checkDue && aEn && almMatch;
  wire rptZero = rpt == 8'h00;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] tvh, tvl, avh, avl, rdMux;
  assign tvh = tPtr == 2'b00 ? tm.minute : tPtr == 2'b01 ? tm.wday :
               tPtr == 2'b10 ? tm.month : `RTCCA_RESET_VAL;
  assign tvl = tPtr == 2'b00 ? tm.second : tPtr == 2'b01 ? tm.hour :
               tPtr == 2'b10 ? tm.day : tm.year;
  assign avh = aPtr == 2'b00 ? alm.minute : aPtr == 2'b01 ? alm.wday :
               aPtr == 2'b10 ? alm.month : `RTCCA_RESET_VAL;
  assign avl = aPtr == 2'b00 ? alm.second : aPtr == 2'b01 ? alm.hour :
               aPtr == 2'b10 ? alm.day : `RTCCA_RESET_VAL;
  wire [7:0] cfgRd = {enable, 1'b0, wren, syncFlag, half_second_status, oe, tPtr};

  always_comb begin
    unique case (bus.addr)
      `RTCCA_OFS_CFG: rdMux = cfgRd;
      `RTCCA_OFS_CAL: rdMux = cal;
      `RTCCA_OFS_PAD: rdMux = {5'h00, padSel, 1'b0};
      `RTCCA_OFS_ACFG: rdMux = {aEn, chime, alarm_interval_mask, aPtr};
      `RTCCA_OFS_RPT: rdMux = rpt;
      `RTCCA_OFS_TVL: rdMux = tvl;
      `RTCCA_OFS_TVH: rdMux = tvh;
      `RTCCA_OFS_AVL: rdMux = avl;
      `RTCCA_OFS_AVH: rdMux = avh;
      default: rdMux = `RTCCA_RESET_VAL;
    endcase
  end

  // ----------------------------------------------------------------
  // clock_config, power-on reset only
  // ----------------------------------------------------------------
  // only rst clears this group
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable <= 1'b0;
      wren <= 1'b0;
      oe <= 1'b0;
      tPtr <= 2'b00;
      unlock <= RTCCA_LOCKED;
    end else begin
      if (wrCfg && wren) begin
        enable <= bus.wdata[`RTCCA_CFG_EN];
      end
      // write enable only after key pair
      if (wrCfg && unlock == RTCCA_ARMED) begin
        wren <= bus.wdata[`RTCCA_CFG_WREN];
      end
      if (wrCfg) begin
        oe <= bus.wdata[`RTCCA_CFG_OE];
        tPtr <= bus.wdata[1:0];
      end else if (accTvh && tPtr != 2'b00) begin
        tPtr <= tPtr - 2'b01;
      end
      if (bus.wr) begin
        unlock <= RTCCA_LOCKED;
        if (wrKey && bus.wdata == `RTCCA_KEY_FIRST) begin
          unlock <= RTCCA_KEY1;
        end else if (wrKey && unlock == RTCCA_KEY1 &&
                     bus.wdata == `RTCCA_KEY_SECOND) begin
          unlock <= RTCCA_ARMED;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // time counting
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tm <= '0;
      presc <= 16'h0000;
      adjLeft <= 10'h000;
      adjNeg <= 1'b0;
      checkDue <= 1'b0;
      checkHalf <= 1'b0;
    end else begin
      tm <= next_tm;
      presc <= secWrite ? 16'h0000 : (countOn ? next_presc : presc);
      if (minTick) begin
        adjLeft <= adjLoad;
        adjNeg <= cal[7];
      end else if (countOn && adjActive) begin
        adjLeft <= adjLeft - 10'h001;
      end
      // compare one cycle later, on the updated time
      checkDue <= secTick || halfTick;
      checkHalf <= halfTick;
    end
  end

  // ----------------------------------------------------------------
  // other control registers, cleared by any reset; alarm time by rst only
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal <= `RTCCA_RESET_VAL;
      padSel <= 2'b00;
      {aEn, chime, alarm_interval_mask, aPtr} <= `RTCCA_RESET_VAL;
      rpt <= `RTCCA_RESET_VAL;
      alm <= '0;
    end else if (sysRst) begin
      cal <= `RTCCA_RESET_VAL;
      padSel <= 2'b00;
      {aEn, chime, alarm_interval_mask, aPtr} <= `RTCCA_RESET_VAL;
      rpt <= `RTCCA_RESET_VAL;
    end else begin
      if (wrCal) begin
        cal <= bus.wdata;
      end
      if (wrPad) begin
        padSel <= bus.wdata[`RTCCA_PAD_SEL_LSB +: 2];
      end
      if (wrAcfg) begin
        aEn <= bus.wdata[`RTCCA_ACFG_EN];
        chime <= bus.wdata[`RTCCA_ACFG_CHIME];
        alarm_interval_mask <= bus.wdata[`RTCCA_ACFG_MASK_LSB +: 4];
        aPtr <= bus.wdata[1:0];
      end else begin
        if (fire && rptZero && !chime) begin
          aEn <= 1'b0;
        end
        if (accAvh && aPtr != 2'b00) begin
          aPtr <= aPtr - 2'b01;
        end
      end
      if (wrRpt) begin
        rpt <= bus.wdata;
      end else if (fire && (!rptZero || chime)) begin
        rpt <= rpt - 8'h01;
      end
      if (wrAvh && almDateOk) begin
        unique case (aPtr)
          2'b00: alm.minute <= bus.wdata & `RTCCA_MASK_MIN;
          2'b01: alm.wday <= bus.wdata & `RTCCA_MASK_WDAY;
          2'b10: alm.month <= bus.wdata & `RTCCA_MASK_MONTH;
          2'b11: alm.minute <= alm.minute;
        endcase
      end
      if (wrAvl && almDateOk) begin
        unique case (aPtr)
          2'b00: alm.second <= bus.wdata & `RTCCA_MASK_SEC;
          2'b01: alm.hour <= bus.wdata & `RTCCA_MASK_HOUR;
          2'b10: alm.day <= bus.wdata & `RTCCA_MASK_DAY;
          2'b11: alm.second <= alm.second;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pin source select, reserved code drives low
  wire pinSrc = padSel == 2'b00 ? fire :
                padSel == 2'b01 ? !half_second_status :
                padSel == 2'b10 ? srcClkLevel : 1'b0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= `RTCCA_RESET_VAL;
      pinOut <= 1'b0;
      pinOe <= 1'b0;
      alarmEvent <= 1'b0;
    end else begin
      rdData <= bus.rd ? rdMux : `RTCCA_RESET_VAL;
      pinOut <= pinSrc;
      pinOe <= oe;
      alarmEvent <= fire;
    end
  end

endmodule

// ---- verilog/rtcca_regs.svh ----
// Purpose: register offsets, field positions, reset values and counts
// Assumes: included by the calendar clock control block
// Notes: byte-wide registers on a plain 4-bit address port
`ifndef RTCCA_REGS_SVH
`define RTCCA_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define RTCCA_OFS_CFG 4'h0
`define RTCCA_OFS_CAL 4'h1
`define RTCCA_OFS_PAD 4'h2
`define RTCCA_OFS_ACFG 4'h3
`define RTCCA_OFS_RPT 4'h4
`define RTCCA_OFS_TVL 4'h5
`define RTCCA_OFS_TVH 4'h6
`define RTCCA_OFS_AVL 4'h7
`define RTCCA_OFS_AVH 4'h8
`define RTCCA_OFS_KEY 4'h9

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define RTCCA_CFG_EN 7
`define RTCCA_CFG_WREN 5
`define RTCCA_CFG_SYNC 4
`define RTCCA_CFG_HALF 3
`define RTCCA_CFG_OE 2
`define RTCCA_PAD_SEL_LSB 1
`define RTCCA_ACFG_EN 7
`define RTCCA_ACFG_CHIME 6
`define RTCCA_ACFG_MASK_LSB 2

// ----------------------------------------------------------------
// values and counts
// ----------------------------------------------------------------
`define RTCCA_RESET_VAL 8'h00
`define RTCCA_KEY_FIRST 8'h55
`define RTCCA_KEY_SECOND 8'hAA
`define RTCCA_TICKS_HALF 16384
`define RTCCA_SYNC_TICKS 8
`define RTCCA_CAL_STEP 4
`define RTCCA_MASK_SEC 8'h7F
`define RTCCA_MASK_MIN 8'h7F
`define RTCCA_MASK_HOUR 8'h3F
`define RTCCA_MASK_DAY 8'h3F
`define RTCCA_MASK_WDAY 8'h07
`define RTCCA_MASK_MONTH 8'h1F
`define RTCCA_MASK_YEAR 8'hFF

`endif

// ---- verilog/rtcca_pkg.sv ----
// Purpose: types of the calendar clock control block
// Assumes: constants come from rtcca_regs.svh
// Notes: all time fields are two BCD digits
package rtcca_pkg;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } rtcca_time_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rtcca_bus_t;

  typedef enum logic [1:0] {
    RTCCA_LOCKED,
    RTCCA_KEY1,
    RTCCA_ARMED
  } rtcca_unlock_t;

endpackage

// ---- tb/rtcca_top_asserts.sv ----
// Purpose: port checks of rtcca_top
// Assumes: lock state and pin select follow from bus writes
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`include "rtcca_regs.svh"

module rtcca_top_asserts (
  // clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic sysRst,
  // register port
  input wire rtcca_pkg::rtcca_bus_t bus,
  input wire logic [7:0] rdData,
  // source and pin
  input wire logic srcTick,
  input wire logic srcClkLevel,
  input wire logic pinOut,
  input wire logic pinOe,
  input wire logic alarmEvent
);
  import rtcca_pkg::*;
  logic keyOne, armed, wren, en, aen;
  logic [1:0] sel;
  wire cfgWr = bus.wr && bus.addr == `RTCCA_OFS_CFG;
  wire cfgRd = bus.rd && bus.addr == `RTCCA_OFS_CFG;
  wire keyWr = bus.wr && bus.addr == `RTCCA_OFS_KEY;

  // ----------------------------------------------------------------
  // shadow of software writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      keyOne <= 1'b0;
      armed <= 1'b0;
      wren <= 1'b0;
      en <= 1'b0;
    end else if (bus.wr) begin
      keyOne <= keyWr && bus.wdata == `RTCCA_KEY_FIRST;
      armed <= keyWr && bus.wdata == `RTCCA_KEY_SECOND && keyOne;
      if (cfgWr && armed)
        wren <= bus.wdata[`RTCCA_CFG_WREN];
      if (cfgWr && wren)
        en <= bus.wdata[`RTCCA_CFG_EN];
    end
  end

  // aen is only set by software, so it bounds the real enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel <= 2'h0;
      aen <= 1'b0;
    end else if (sysRst) begin
      sel <= 2'h0;
      aen <= 1'b0;
    end else if (bus.wr) begin
      if (bus.addr == `RTCCA_OFS_PAD)
        sel <= bus.wdata[2:1];
      if (bus.addr == `RTCCA_OFS_ACFG)
        aen <= bus.wdata[`RTCCA_ACFG_EN];
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_sync_en: assert property (
    $past(cfgRd) && rdData[4] |-> rdData[7])
    else $error("sync flag seen while disabled");
  a_wren_unlock: assert property (
    $past(cfgRd) |-> rdData[5] == $past(wren))
    else $error("write enable changed without unlock");
  a_en_locked: assert property (
    $past(cfgRd) |-> rdData[7] == $past(en))
    else $error("module enable took a locked write");
  a_oe_write: assert property (
    $past(cfgWr, 2) |-> pinOe == $past(bus.wdata[`RTCCA_CFG_OE], 2))
    else $error("pin enable does not follow write");
  a_oe_hold: assert property (
    !$past(cfgWr, 2) |-> $stable(pinOe))
    else $error("pin enable moved without write");
  a_pin_raw: assert property (
    pinOe && $past(sel) == 2'h2 |-> pinOut == $past(srcClkLevel))
    else $error("pin does not show source clock");
  a_pin_rsvd: assert property (
    pinOe && $past(sel) == 2'h3 |-> !pinOut)
    else $error("pin not low for reserved select");
  a_event_once: assert property (
    alarmEvent |=> !alarmEvent)
    else $error("alarm event longer than one cycle");
  a_event_en: assert property (
    alarmEvent |-> aen)
    else $error("alarm event while alarm disabled");
endmodule

bind rtcca_top rtcca_top_asserts i_chk (
  .clk(clk), .rst(rst), .sysRst(sysRst), .bus(bus), .rdData(rdData),
  .srcTick(srcTick), .srcClkLevel(srcClkLevel), .pinOut(pinOut),
  .pinOe(pinOe), .alarmEvent(alarmEvent)
);

// ---- tb/tb.sv ----
// Purpose: directed bench of the calendar clock control block
// Assumes: source ticks four clocks apart, short prescaler
// Notes: a second is 2*HALF source ticks here
`timescale 1ns/1ps
`include "rtcca_regs.svh"

module tb;
  import rtcca_pkg::*;
  localparam int HALF = 16;
  localparam logic [3:0] CFG = `RTCCA_OFS_CFG;
  localparam logic [3:0] CAL = `RTCCA_OFS_CAL;
  localparam logic [3:0] PAD = `RTCCA_OFS_PAD;
  localparam logic [3:0] ACFG = `RTCCA_OFS_ACFG;
  localparam logic [3:0] RPT = `RTCCA_OFS_RPT;
  localparam logic [3:0] TVL = `RTCCA_OFS_TVL;
  localparam logic [3:0] TVH = `RTCCA_OFS_TVH;
  localparam logic [3:0] KEY = `RTCCA_OFS_KEY;
  localparam logic [3:0] AVL = `RTCCA_OFS_AVL;
  localparam logic [3:0] AVH = `RTCCA_OFS_AVH;
  logic clk, rst, sysRst, srcTick, srcClkLevel;
  logic pinOut, pinOe, alarmEvent;
  logic [7:0] rdData;
  rtcca_bus_t bus;
  int errTotal, totalChecks, events, base;
  // year, reserved, day, month, hours, weekday, seconds, minutes
  logic [7:0] vals [8] = '{8'h24, 8'h77, 8'h15, 8'h11,
                           8'h09, 8'h03, 8'h30, 8'h45};

  rtcca_top #(.TICKS_HALF(HALF)) i_dut (
    .clk(clk), .rst(rst), .sysRst(sysRst), .bus(bus), .rdData(rdData),
    .srcTick(srcTick), .srcClkLevel(srcClkLevel), .pinOut(pinOut),
    .pinOe(pinOe), .alarmEvent(alarmEvent)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
    if (alarmEvent === 1'b1)
      events <= events + 1;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    totalChecks++;
    if (g !== e) begin
      errTotal++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdData, e);
  endtask

  task automatic unlock(input logic [7:0] d);
    wr(KEY, `RTCCA_KEY_FIRST);
    wr(KEY, `RTCCA_KEY_SECOND);
    wr(CFG, d);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      srcTick <= 1'b1;
      srcClkLevel <= ~srcClkLevel;
      @(posedge clk);
      srcTick <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  // minute rollover from 59, then seconds edge moved by the code
  task automatic calRun(input logic [7:0] c, input int a, input int b);
    wr(CAL, c);
    wr(TVL, 8'h59);
    tick(2 * HALF);
    tick(a);
    rdc(TVL, 8'h00);
    tick(b);
    rdc(TVL, 8'h01);
  endtask

  task automatic summarize;
    if (errTotal == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    sysRst = 1'b0;
    srcTick = 1'b0;
    srcClkLevel = 1'b0;
    bus = '{4'h0, 8'h00, 1'b0, 1'b0};
    errTotal = 0;
    totalChecks = 0;
    events = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++)
      rdc(4'(a), 8'h00);
    wr(CFG, 8'hA0);
    rdc(CFG, 8'h00);
    wr(TVL, 8'h12);
    rdc(TVL, 8'h00);
    unlock(8'h23);
    for (int i = 0; i < 8; i++)
      wr(TVL + 4'(i % 2), vals[i]);
    wr(CFG, 8'hA3);
    for (int i = 0; i < 8; i++)
      rdc(TVL + 4'(i % 2), i == 1 ? 8'h00 : vals[i]);
    rdc(TVH, 8'h45);
    rdc(CFG, 8'hA0);
    unlock(8'h80);
    wr(TVL, 8'h55);
    rdc(TVL, 8'h30);
    wr(CFG, 8'h82);
    wr(TVH, 8'h12);
    wr(CFG, 8'h82);
    rdc(TVH, 8'h11);
    unlock(8'hA0);
    wr(TVL, 8'h30);
    tick(HALF - 1);
    rdc(CFG, 8'hA0);
    tick(1);
    rdc(CFG, 8'hA8);
    tick(HALF - 4);
    rdc(CFG, 8'hB8);
    wr(TVL, 8'h30);
    rdc(CFG, 8'hA0);
    tick(2 * HALF);
    rdc(TVL, 8'h31);
    wr(CFG, 8'h20);
    tick(2 * HALF);
    rdc(TVL, 8'h31);
    wr(CFG, 8'hA0);
    calRun(8'h01, 26, 4);
    calRun(8'hFF, 32, 6);
    wr(CAL, 8'h33);
    @(posedge clk);
    sysRst <= 1'b1;
    @(posedge clk);
    sysRst <= 1'b0;
    rdc(CFG, 8'hA0);
    rdc(CAL, 8'h00);
    wr(PAD, 8'h02);
    wr(CFG, 8'hA4);
    wr(TVL, 8'h30);
    tick(2);
    #1 chk({7'h00, pinOut}, 8'h01);
    chk({7'h00, pinOe}, 8'h01);
    tick(HALF);
    #1 chk({7'h00, pinOut}, 8'h00);
    wr(PAD, 8'h04);
    tick(4);
    wr(PAD, 8'h06);
    tick(4);
    wr(PAD, 8'h00);
    wr(RPT, 8'h02);
    wr(ACFG, 8'h84);
    base = events;
    tick(8 * HALF);
    chk(8'(events - base), 8'h03);
    rdc(RPT, 8'h00);
    rdc(ACFG, 8'h04);
    wr(ACFG, 8'hC4);
    tick(2 * HALF);
    rdc(RPT, 8'hFF);
    rdc(ACFG, 8'hC4);
    wr(RPT, 8'h01);
    wr(ACFG, 8'h80);
    base = events;
    tick(2 * HALF);
    chk(8'(events - base), 8'h02);
    rdc(ACFG, 8'h00);
    wr(ACFG, 8'h02);
    wr(AVH, 8'h12);
    wr(AVL, 8'h08);
    wr(AVH, 8'h05);
    wr(AVL, 8'h15);
    wr(AVH, 8'h33);
    wr(ACFG, 8'h02);
    rdc(AVH, 8'h12);
    rdc(AVL, 8'h08);
    rdc(AVH, 8'h05);
    rdc(AVL, 8'h15);
    rdc(AVH, 8'h33);
    rdc(ACFG, 8'h00);
    wr(CFG, 8'hA6);
    wr(TVL, 8'h28);
    wr(TVH, 8'h02);
    wr(TVL, 8'h23);
    wr(TVH, 8'h06);
    wr(TVL, 8'h59);
    wr(TVH, 8'h59);
    tick(2 * HALF);
    wr(CFG, 8'hA6);
    rdc(TVL, 8'h29);
    rdc(TVH, 8'h02);
    summarize();
  end
endmodule
